// ===== core/serial_flash_addr_protect.sv
// Serial flash command framing, address width and write protection
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Levels 1-9 protect 2^(n-1) blocks top/bottom
// - Levels 10-15 protect all 512 blocks
// - Security bit 0 shows factory lock
// - Security write command sets customer lock bit
// - Any lock permanently blocks secure changes
// - Secure mode forbids main array access
// - Offsets 000-00F serial, 010-1FF customer
// - Unknown command: standby, output off, until select
// - Valid command stays active until select rises
// - Sample on rising, shift out on falling
// - Reads may end after any output bit
// - Write-type commands need exact byte boundary
// - Busy ignores array access attempts
// - Enter/exit wide command sets/clears 32-bit mode
// - Wide variants always take 32-bit address
// - Wide mode ignores segment select bit
// - Upper address register, bit 0 only, reset 0
// - Narrow addresses stay in selected segment
// - Continuous read crosses into next segment
// - Chip erase ignores segment selection
// - Reject program/erase in protected blocks
// - Data-changing commands need write enable latch
module serial_flash_addr_protect
(
	input wire logic clk,
	input wire logic nrst,
	input wire flash_protect_pkg::apbReq_type apbReq,
	output var flash_protect_pkg::apbRsp_type apbRsp,
	input wire logic sclk,
	input wire logic csN,
	input wire logic si,
	input wire logic [7:0] arrayRdData,
	output var logic so,
	output var logic soOe,
	output var flash_protect_pkg::arrayReq_type arrayReq,
	output var logic arrayReqValid,
	output var logic cmdReject
);
	import flash_protect_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [2:0] pinMeta_q; // First sync stage {sclk, csN, si}
	logic [2:0] pinSync_q; // Second sync stage
	logic [2:0] pinPrev_q; // Delayed copy for edges
	logic sclkRise, sclkFall, csFall, csRise, siBit;
	state_type state_q; // Framing state
	logic [7:0] shift_q; // Input shifter
	logic [7:0] newByte; // Completed input byte
	logic [2:0] bitCnt_q; // Bits in current byte
	logic [2:0] byteCnt_q; // Address bytes taken
	logic [2:0] addrBytes_q; // Address length of command
	logic [7:0] opcode_q; // Current command
	logic [31:0] addr_q; // Shifted address
	logic [7:0] dataByte_q; // First data byte
	logic [8:0] dataCnt_q; // Data bytes taken
	logic [7:0] outShift_q; // Output shifter
	logic [2:0] outCnt_q; // Output bit count
	logic byteDone; // Byte completes on this edge
	cmdInfo_type info; // Decode of the incoming byte
	cmdInfo_type curInfo; // Decode of the latched command
	logic wel_q, wideAddr_q, secure_q, custLock_q, factoryLock_q, busy_q, tb_q;
	logic [3:0] level_q; // Protect level
	logic ear_q; // Segment select bit
	logic [24:0] rdAddr_q; // Continuous read pointer
	logic [31:0] effAddr; // Address after width and segment
	logic [24:0] startAddr; // Read start address, last byte included
	logic readStart, readNext, framedOk, isRead, chipErase;
	logic [7:0] statusByte, securityByte, earByte, srcByte;
	logic apbDo; // APB completion edge
	logic [31:0] rdMux;
	logic rdErr;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Command table
	function automatic cmdInfo_type decode(input logic [7:0] c);
		cmdInfo_type r;
		r = '0;
		r.known = 1'b1;
		case (c)
			CMD_WRITE_ENABLE, CMD_WRITE_DISABLE, CMD_ENTER_SECURE, CMD_EXIT_SECURE,
			CMD_SECURITY_WRITE, CMD_ENTER_WIDE, CMD_EXIT_WIDE, CMD_CHIP_ERASE,
			CMD_CHIP_ERASE_ALT, CMD_STATUS_WRITE, CMD_UPPER_ADDR_WRITE:
				r.framed = 1'b1;
			CMD_PROGRAM, CMD_SECTOR_ERASE, CMD_BLOCK_ERASE:
				r = '{known: 1'b1, framed: 1'b1, hasAddr: 1'b1, force4: 1'b0, dataOut: 1'b0};
			CMD_PROGRAM_WIDE, CMD_SECTOR_ERASE_WIDE, CMD_BLOCK_ERASE_WIDE:
				r = '{known: 1'b1, framed: 1'b1, hasAddr: 1'b1, force4: 1'b1, dataOut: 1'b0};
			CMD_READ:
				r = '{known: 1'b1, framed: 1'b0, hasAddr: 1'b1, force4: 1'b0, dataOut: 1'b1};
			CMD_READ_WIDE:
				r = '{known: 1'b1, framed: 1'b0, hasAddr: 1'b1, force4: 1'b1, dataOut: 1'b1};
			CMD_STATUS_READ, CMD_SECURITY_READ, CMD_UPPER_ADDR_READ:
				r.dataOut = 1'b1;
			default:
				r.known = 1'b0;
		endcase
		return r;
	endfunction

	// Block protection test
	function automatic logic protectedBlock(input logic [BLOCK_W-1:0] blk,
		input logic [3:0] lvl, input logic tb);
		logic [9:0] cnt;
		cnt = 10'h001 << (lvl - 4'h1);
		if (lvl == PROTECT_NONE_LEVEL)
			return 1'b0;
		if (lvl >= PROTECT_ALL_LEVEL)
			return 1'b1;
		if (tb)
			return {1'b0, blk} < cnt;
		return {1'b0, blk} >= (BLOCK_COUNT - cnt);
	endfunction

	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	// Two stages on sclk, csN, si
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pinMeta_q <= 3'h2;
			pinSync_q <= 3'h2;
			pinPrev_q <= 3'h2;
		end
		else
		begin
			pinMeta_q <= {sclk, csN, si};
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
		end
	end

	// edges for both clock idle levels
	assign sclkRise = pinSync_q[2] & ~pinPrev_q[2] & ~pinSync_q[1];
	assign sclkFall = ~pinSync_q[2] & pinPrev_q[2] & ~pinSync_q[1];
	assign csFall = ~pinSync_q[1] & pinPrev_q[1];
	assign csRise = pinSync_q[1] & ~pinPrev_q[1];
	assign siBit = pinSync_q[0];

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	assign newByte = {shift_q[6:0], siBit};
	assign byteDone = sclkRise && (bitCnt_q == LAST_BIT);
	assign info = decode(newByte);
	assign curInfo = decode(opcode_q);
	assign isRead = (opcode_q == CMD_READ) || (opcode_q == CMD_READ_WIDE);
	assign chipErase = (opcode_q == CMD_CHIP_ERASE) || (opcode_q == CMD_CHIP_ERASE_ALT);
	// segment bit only for narrow addresses
	assign effAddr = (addrBytes_q == ADDR_BYTES_WIDE) ? addr_q :
		{7'h00, ear_q, addr_q[23:0]};
	// read start takes the byte completing now
	assign startAddr = (addrBytes_q == ADDR_BYTES_WIDE) ? {addr_q[16:0], newByte} :
		{ear_q, addr_q[15:0], newByte};
	assign readStart = byteDone && (state_q == ST_ADDR) && isRead &&
		(byteCnt_q == addrBytes_q - 3'h1);
	assign readNext = sclkFall && (state_q == ST_OUT) && isRead && (outCnt_q == 3'h0);
	// framed command ends on a byte boundary
	assign framedOk = curInfo.framed && (state_q == ST_DATA) && (bitCnt_q == 3'h0);
	assign statusByte = {wideAddr_q, tb_q, level_q, wel_q, busy_q};
	assign securityByte = {5'h00, secure_q, custLock_q, factoryLock_q};
	assign earByte = {7'h00, ear_q};
	assign apbDo = apbReq.psel && apbReq.penable && apbRsp.pready;

	// ----------------------------------------
	// Command framing
	// ----------------------------------------
	// Shifting, counting and state
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bitCnt_q <= 3'h0;
			byteCnt_q <= 3'h0;
			addrBytes_q <= ADDR_BYTES_NARROW;
			opcode_q <= 8'h00;
			addr_q <= 32'h00000000;
			dataByte_q <= 8'h00;
			dataCnt_q <= 9'h000;
		end
		else if (csRise)
		begin
			state_q <= ST_IDLE;
			bitCnt_q <= 3'h0;
		end
		else if (csFall)
		begin
			// Fresh frame, command state entered here; standby was already left at select rise
			state_q <= ST_CMD;
			// Forget the last command so a short frame is not judged by it
			opcode_q <= 8'h00;
			bitCnt_q <= 3'h0;
			byteCnt_q <= 3'h0;
			addr_q <= 32'h00000000;
			dataCnt_q <= 9'h000;
		end
		else if (sclkRise && (state_q == ST_CMD || state_q == ST_ADDR || state_q == ST_DATA))
		begin
			shift_q <= newByte;
			bitCnt_q <= bitCnt_q + 3'h1;
			if (byteDone)
			begin
				case (state_q)
					ST_CMD:
					begin
						opcode_q <= newByte;
						addrBytes_q <= (info.force4 || wideAddr_q) ? ADDR_BYTES_WIDE :
							ADDR_BYTES_NARROW;
						if (!info.known)
							state_q <= ST_STANDBY;
						else if (info.hasAddr)
							state_q <= ST_ADDR;
						else if (info.dataOut)
							state_q <= ST_OUT;
						else
							state_q <= ST_DATA;
					end
					ST_ADDR:
					begin
						addr_q <= {addr_q[23:0], newByte};
						byteCnt_q <= byteCnt_q + 3'h1;
						if (byteCnt_q == addrBytes_q - 3'h1)
							state_q <= curInfo.dataOut ? ST_OUT : ST_DATA;
					end
					ST_DATA:
					begin
						if (dataCnt_q == 9'h000)
							dataByte_q <= newByte;
						if (dataCnt_q != 9'h1ff)
							dataCnt_q <= dataCnt_q + 9'h001;
					end
					default:
						state_q <= state_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Serial output
	// ----------------------------------------
	always_comb
	begin
		case (opcode_q)
			CMD_STATUS_READ: srcByte = statusByte;
			CMD_SECURITY_READ: srcByte = securityByte;
			CMD_UPPER_ADDR_READ: srcByte = earByte;
			default: srcByte = arrayRdData;
		endcase
	end

	// shift out on falling edges, drop at select rise
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			so <= 1'b0;
			soOe <= 1'b0;
			outShift_q <= 8'h00;
			outCnt_q <= 3'h0;
		end
		else if (state_q != ST_OUT || csRise)
		begin
			so <= 1'b0;
			soOe <= 1'b0;
			outCnt_q <= 3'h0;
		end
		else if (sclkFall)
		begin
			soOe <= 1'b1;
			outCnt_q <= outCnt_q + 3'h1;
			if (outCnt_q == 3'h0)
			begin
				so <= srcByte[7];
				outShift_q <= {srcByte[6:0], 1'b0};
			end
			else
			begin
				so <= outShift_q[7];
				outShift_q <= {outShift_q[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Execution and protection state
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wel_q <= 1'b0;
			wideAddr_q <= 1'b0;
			secure_q <= 1'b0;
			custLock_q <= 1'b0;
			factoryLock_q <= 1'b0;
			busy_q <= 1'b0;
			level_q <= 4'h0;
			tb_q <= 1'b0;
			ear_q <= 1'b0;
			rdAddr_q <= 25'h0000000;
			arrayReq <= '0;
			arrayReqValid <= 1'b0;
			cmdReject <= 1'b0;
		end
		else
		begin
			arrayReqValid <= 1'b0;
			cmdReject <= 1'b0;
			// Software side: protect, factory lock, busy
			if (apbDo && apbReq.pwrite)
			begin
				if (apbReq.paddr == REG_PROTECT)
				begin
					level_q <= apbReq.pwdata[3:0];
					tb_q <= apbReq.pwdata[4];
				end
				if (apbReq.paddr == REG_SECURITY && apbReq.pwdata[SEC_FACTORY])
					factoryLock_q <= 1'b1;
				if (apbReq.paddr == REG_BUSY)
					busy_q <= apbReq.pwdata[0];
			end
			if (readStart)
			begin
				// busy read ignored, secure read stays in area
				if (busy_q)
					cmdReject <= 1'b1;
				else
				begin
					arrayReq.op <= OP_READ;
					arrayReq.secure <= secure_q;
					arrayReq.len <= 9'h000;
					// secure read stays inside the secure area
					if (secure_q)
						arrayReq.addr <= {23'h000000, startAddr[SECURE_ADDR_W-1:0]};
					else
						arrayReq.addr <= {7'h00, startAddr};
					rdAddr_q <= startAddr;
					arrayReqValid <= 1'b1;
				end
			end
			else if (readNext && !busy_q)
			begin
				// pointer runs across segments and wraps
				rdAddr_q <= rdAddr_q + 25'h0000001;
				arrayReq.addr <= {7'h00, rdAddr_q + 25'h0000001};
				if (secure_q)
					arrayReq.addr <= {23'h000000, rdAddr_q[SECURE_ADDR_W-1:0] + 9'h001};
				arrayReqValid <= 1'b1;
			end
			else if (csRise && curInfo.framed && !framedOk && state_q != ST_STANDBY)
				cmdReject <= 1'b1;
			else if (csRise && framedOk)
			begin
				arrayReq.addr <= {7'h00, effAddr[24:0]};
				arrayReq.secure <= secure_q;
				arrayReq.len <= dataCnt_q;
				case (opcode_q)
					CMD_WRITE_ENABLE: wel_q <= 1'b1;
					CMD_WRITE_DISABLE: wel_q <= 1'b0;
					CMD_ENTER_WIDE: wideAddr_q <= 1'b1;
					CMD_EXIT_WIDE: wideAddr_q <= 1'b0;
					CMD_ENTER_SECURE: secure_q <= 1'b1;
					CMD_EXIT_SECURE: secure_q <= 1'b0;
					CMD_UPPER_ADDR_WRITE:
						if (dataCnt_q == 9'h000)
							cmdReject <= 1'b1;
						else
							ear_q <= dataByte_q[0];
					CMD_STATUS_WRITE:
						if (!wel_q || busy_q || dataCnt_q == 9'h000)
							cmdReject <= 1'b1;
						else
						begin
							level_q <= dataByte_q[STAT_LEVEL_LO+3:STAT_LEVEL_LO];
							tb_q <= dataByte_q[STAT_TB];
							wel_q <= 1'b0;
						end
					CMD_SECURITY_WRITE:
						if (!wel_q || busy_q)
							cmdReject <= 1'b1;
						else
						begin
							custLock_q <= 1'b1;
							wel_q <= 1'b0;
						end
					CMD_PROGRAM, CMD_PROGRAM_WIDE:
					begin
						arrayReq.op <= OP_PROGRAM;
						if (!wel_q || busy_q || dataCnt_q == 9'h000)
							cmdReject <= 1'b1;
						else if (secure_q && (factoryLock_q || custLock_q ||
							effAddr[SECURE_ADDR_W-1:0] < SECURE_CUSTOMER_FIRST))
							cmdReject <= 1'b1;
						else if (!secure_q && protectedBlock(effAddr[24:16], level_q, tb_q))
							cmdReject <= 1'b1;
						else
						begin
							if (secure_q)
								arrayReq.addr <= {23'h000000, effAddr[SECURE_ADDR_W-1:0]};
							arrayReqValid <= 1'b1;
							wel_q <= 1'b0;
						end
					end
					default:
					begin
						// Sector, block and chip erase
						if (opcode_q == CMD_SECTOR_ERASE || opcode_q == CMD_SECTOR_ERASE_WIDE)
							arrayReq.op <= OP_SECTOR_ERASE;
						else if (chipErase)
							arrayReq.op <= OP_CHIP_ERASE;
						else
							arrayReq.op <= OP_BLOCK_ERASE;
						if (chipErase)
							arrayReq.addr <= 32'h00000000;
						if (secure_q || !wel_q || busy_q)
							cmdReject <= 1'b1;
						else if (chipErase && level_q != PROTECT_NONE_LEVEL)
							cmdReject <= 1'b1;
						else if (!chipErase && protectedBlock(effAddr[24:16], level_q, tb_q))
							cmdReject <= 1'b1;
						else
						begin
							arrayReqValid <= 1'b1;
							wel_q <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb
	begin
		rdErr = 1'b0;
		case (apbReq.paddr)
			REG_STATUS: rdMux = {24'h000000, statusByte};
			REG_PROTECT: rdMux = {27'h0000000, tb_q, level_q};
			REG_SECURITY: rdMux = {24'h000000, securityByte};
			REG_UPPER_ADDR: rdMux = {24'h000000, earByte};
			REG_BUSY: rdMux = {31'h00000000, busy_q};
			REG_LAST_ADDR: rdMux = arrayReq.addr;
			REG_LAST_OP: rdMux = {19'h00000, arrayReq.len, arrayReq.secure, arrayReq.op};
			default:
			begin
				rdMux = 32'h00000000;
				rdErr = 1'b1;
			end
		endcase
	end

	// One wait state, then answer
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			apbRsp <= '0;
		else
		begin
			apbRsp.pready <= apbReq.psel && apbReq.penable && !apbRsp.pready;
			apbRsp.prdata <= apbReq.pwrite ? 32'h00000000 : rdMux;
			apbRsp.pslverr <= apbReq.psel && apbReq.penable && !apbRsp.pready && rdErr;
		end
	end
endmodule
`default_nettype wire

// ===== inc/flash_protect_pkg.sv
// Constants, types and register map of the serial flash protection front end
package flash_protect_pkg;
	// ----------------------------------------
	// Sizes and array geometry
	// ----------------------------------------
	localparam int ADDR_W = 32;
	localparam int ARRAY_ADDR_W = 25;
	localparam int BLOCK_W = 9;
	localparam logic [9:0] BLOCK_COUNT = 10'h200;
	localparam logic [3:0] PROTECT_ALL_LEVEL = 4'ha;
	localparam logic [3:0] PROTECT_NONE_LEVEL = 4'h0;
	localparam int SEGMENT_BIT = 24;
	localparam int SECURE_ADDR_W = 9;
	localparam logic [8:0] SECURE_CUSTOMER_FIRST = 9'h010;
	localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
	localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_READ_WIDE = 8'h13;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_PROGRAM_WIDE = 8'h12;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_SECTOR_ERASE_WIDE = 8'h21;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
	localparam logic [7:0] CMD_BLOCK_ERASE_WIDE = 8'hdc;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h60;
	localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'hc7;
	localparam logic [7:0] CMD_ENTER_SECURE = 8'hb1;
	localparam logic [7:0] CMD_EXIT_SECURE = 8'hc1;
	localparam logic [7:0] CMD_SECURITY_WRITE = 8'h2f;
	localparam logic [7:0] CMD_SECURITY_READ = 8'h2b;
	localparam logic [7:0] CMD_ENTER_WIDE = 8'hb7;
	localparam logic [7:0] CMD_EXIT_WIDE = 8'he9;
	localparam logic [7:0] CMD_UPPER_ADDR_WRITE = 8'hc5;
	localparam logic [7:0] CMD_UPPER_ADDR_READ = 8'hc8;
	// ----------------------------------------
	// Status and security byte fields
	// ----------------------------------------
	localparam int STAT_BUSY = 0;
	localparam int STAT_WEL = 1;
	localparam int STAT_LEVEL_LO = 2;
	localparam int STAT_TB = 6;
	localparam int STAT_WIDE = 7;
	localparam int SEC_FACTORY = 0;
	localparam int SEC_CUSTOMER = 1;
	localparam int SEC_MODE = 2;
	// ----------------------------------------
	// APB register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_PROTECT = 8'h04;
	localparam logic [7:0] REG_SECURITY = 8'h08;
	localparam logic [7:0] REG_UPPER_ADDR = 8'h0c;
	localparam logic [7:0] REG_BUSY = 8'h10;
	localparam logic [7:0] REG_LAST_ADDR = 8'h14;
	localparam logic [7:0] REG_LAST_OP = 8'h18;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
		OP_CHIP_ERASE} op_type;
	typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_OUT, ST_STANDBY} state_type;
	typedef struct packed {
		logic known;
		logic framed;
		logic hasAddr;
		logic force4;
		logic dataOut;
	} cmdInfo_type;
	typedef struct packed {
		op_type op;
		logic secure;
		logic [ADDR_W-1:0] addr;
		logic [8:0] len;
	} arrayReq_type;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apbReq_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apbRsp_type;
endpackage

// ===== dv/spi_host_model.sv
// SPI host model driving flash frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
	output var logic sclk,
	output var logic csN,
	output var logic si,
	input wire logic so
);
	logic cpol = 1'b0; // Idle clock level
	logic [63:0] rx; // Bits seen on so
	initial
	begin
		sclk = 1'b0;
		csN = 1'b1;
		si = 1'b0;
	end
	// One frame, n bits MSB first
	task automatic xfer(input logic [63:0] d, input int n);
		rx = '0;
		sclk = cpol;
		// Odd offset keeps pin edges away from the clock edges
		#102 csN = 1'b0;
		#62.5;
		// Drive on fall, sample on rise
		for (int i = 0; i < n; i++)
		begin
			sclk = 1'b0;
			si = d[63-i];
			#62.5 sclk = 1'b1;
			rx = {rx[62:0], so};
			#62.5;
		end
		sclk = cpol;
		#62.5 csN = 1'b1;
		si = ~si;
		#100;
	endtask
endmodule
`default_nettype wire

// ===== dv/serial_flash_addr_protect_properties.sv
// Port checker of the flash protection block
`timescale 1ns/10ps
`default_nettype none
module serial_flash_addr_protect_properties
(
	input wire logic clk,
	input wire logic nrst,
	input wire flash_protect_pkg::apbReq_type apbReq,
	input wire flash_protect_pkg::apbRsp_type apbRsp,
	input wire logic sclk,
	input wire logic csN,
	input wire logic si,
	input wire logic [7:0] arrayRdData,
	input wire logic so,
	input wire logic soOe,
	input wire flash_protect_pkg::arrayReq_type arrayReq,
	input wire logic arrayReqValid,
	input wire logic cmdReject
);
	import flash_protect_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	idle_output_off_a: assert property (csN [*8] |-> !soOe && !so)
		else $error("so driven while deselected");
	out_off_after_a: assert property ($rose(csN) |-> ##[1:8] !soOe)
		else $error("so enable stays after frame");
	out_after_fall_a: assert property (soOe && $past(soOe) && $changed(so) |-> !$past(sclk, 2))
		else $error("so changed off falling edge");
	secure_offset_range_a: assert property (arrayReqValid && arrayReq.secure |-> arrayReq.addr < 32'h200)
		else $error("secure offset too wide");
	array_addr_range_a: assert property (arrayReqValid && !arrayReq.secure |-> arrayReq.addr[31:25] == 7'h00)
		else $error("array address too wide");
	reject_no_req_a: assert property (cmdReject |-> !arrayReqValid ##1 !cmdReject)
		else $error("refusal with request");
	req_single_pulse_a: assert property (arrayReqValid |=> !arrayReqValid)
		else $error("request pulse too long");
	ready_after_access_a: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
		else $error("bus answer late");
	error_with_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready ##1 !apbRsp.pready)
		else $error("bus error without ready");
	cover property (arrayReqValid && arrayReq.secure);
	cover property (cmdReject);
	cover property ($rose(soOe));
	cover property (apbRsp.pslverr);
endmodule
bind serial_flash_addr_protect serial_flash_addr_protect_properties chk
(
	.clk(clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp), .sclk(sclk), .csN(csN), .si(si),
	.arrayRdData(arrayRdData), .so(so), .soOe(soOe), .arrayReq(arrayReq),
	.arrayReqValid(arrayReqValid), .cmdReject(cmdReject)
);
`default_nettype wire

// ===== dv/serial_flash_addr_protect_bench.sv
// Self-checking bench of the flash protection block
`timescale 1ns/10ps
`default_nettype none
module serial_flash_addr_protect_bench;
	import flash_protect_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0; // Reset, active low
	apbReq_type apbReq = '0;
	apbRsp_type apbRsp;
	logic sclk, csN, si, so, soOe, arrayReqValid, cmdReject, err, oeSeen;
	logic soLine; // Data line as the host sees it
	logic [7:0] arrayRdData = 8'h00;
	logic [31:0] rd;
	arrayReq_type arrayReq;
	arrayReq_type reqQ[$]; // Requests seen
	int nRej = 0;
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 39;
	int q0;
	initial
	begin
		forever #5 clk = ~clk;
	end
	serial_flash_addr_protect uut (.clk(clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
		.sclk(sclk), .csN(csN), .si(si), .arrayRdData(arrayRdData), .so(so), .soOe(soOe),
		.arrayReq(arrayReq), .arrayReqValid(arrayReqValid), .cmdReject(cmdReject));
	// Released line reads high, since so is cleared together with its enable
	assign soLine = soOe ? so : ~so;
	spi_host_model host (.sclk(sclk), .csN(csN), .si(si), .so(soLine));
	// Pulse monitor
	always @(posedge clk)
	begin
		if (arrayReqValid === 1'b1)
			reqQ.push_back(arrayReq);
		if (cmdReject === 1'b1)
			nRej++;
		if (soOe === 1'b1)
			oeSeen = 1'b1;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Bus transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (apbRsp.pready !== 1'b1 && k < 20);
		if (apbRsp.pready !== 1'b1)
		begin
			n_mismatch++;
			close_out;
		end
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// Frame with expected pulse counts, -1 skips
	task automatic spi(input logic [63:0] d, input int n, input int eq, input int ej);
		int j0;
		q0 = reqQ.size();
		j0 = nRej;
		oeSeen = 1'b0;
		host.xfer(d << (64 - n), n);
		repeat (10) @(posedge clk);
		if (eq >= 0)
			chk("requests", eq, reqQ.size() - q0);
		if (ej >= 0)
			chk("refusals", ej, nRej - j0);
	endtask
	function automatic int prot(input logic [3:0] lv, input logic tb, input logic [8:0] b);
		if (lv == 4'h0)
			return 0;
		if (lv >= 4'ha)
			return 1;
		if (tb)
			return int'({1'b0, b} < (10'h1 << (lv - 1)));
		return int'({1'b0, b} >= 10'h200 - (10'h1 << (lv - 1)));
	endfunction
	initial
	begin
		logic [3:0] lv;
		logic tb;
		logic [8:0] b;
		logic wl;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("upper reset", REG_UPPER_ADDR, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, REG_UPPER_ADDR, 32'hff);
		rchk("upper read only", REG_UPPER_ADDR, 32'h0);
		spi(64'hb7, 8, 0, 0);
		rchk("wide on", REG_STATUS, 32'h80);
		spi(64'he9, 8, 0, 0);
		rchk("wide off", REG_STATUS, 32'h0);
		spi(64'h00c, 9, 0, 1);
		spi(64'h02000000a5, 40, 0, 1);
		spi(64'hff06, 16, 0, 0);
		chk("standby output", 32'h0, {31'h0, oeSeen});
		rchk("no latch", REG_STATUS, 32'h0);
		$display("test framing done");
		wl = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			lv = (i == 0) ? 4'h9 : 4'($random(seed));
			tb = 1'($random(seed));
			b = 9'($random(seed));
			apb(1'b1, REG_PROTECT, {27'h0, tb, lv});
			// Latch stays set after a refused erase
			rchk("status level", REG_STATUS, {25'h0, tb, lv, wl, 1'b0});
			spi(64'h06, 8, 0, 0);
			spi({24'h0, 8'h21, 7'h0, b, 16'h0}, 40, 1 - prot(lv, tb, b), prot(lv, tb, b));
			wl = (prot(lv, tb, b) == 1);
		end
		$display("test protect done");
		apb(1'b1, REG_BUSY, 32'h1);
		spi(64'h030001000, 36, 0, 1);
		apb(1'b1, REG_BUSY, 32'h0);
		spi(64'hc501, 16, 0, 0);
		rchk("upper set", REG_UPPER_ADDR, 32'h1);
		spi(64'hc800, 16, 0, 0);
		chk("upper out", 32'h1, {24'h0, host.rx[7:0]});
		spi(64'h06, 8, 0, 0);
		spi(64'h0124, 16, 0, 0);
		rchk("status write", REG_PROTECT, 32'h9);
		spi(64'h028, 11, 0, 0);
		apb(1'b1, REG_PROTECT, 32'h0);
		spi(64'h06, 8, 0, 0);
		spi(64'h60, 8, 1, 0);
		chk("chip op", OP_CHIP_ERASE, reqQ[q0].op);
		rchk("chip addr", REG_LAST_ADDR, 32'h0);
		rchk("chip last op", REG_LAST_OP, 32'h4);
		arrayRdData <= 8'($random(seed));
		spi(64'h03fffffe000000, 56, -1, 0);
		chk("segment addr", 32'h01fffffe, reqQ[q0].addr);
		chk("wrap addr", 32'h0, reqQ[q0+2].addr);
		chk("read data", {24'h0, arrayRdData}, {24'h0, host.rx[23:16]});
		spi(64'hb7, 8, 0, 0);
		host.cpol = 1'b1;
		spi(64'h0300fffffe000000, 64, -1, 0);
		chk("wide addr", 32'h00fffffe, reqQ[q0].addr);
		chk("cross addr", 32'h01000000, reqQ[q0+2].addr);
		chk("mode 3 data", {24'h0, arrayRdData}, {24'h0, host.rx[23:16]});
		host.cpol = 1'b0;
		spi(64'he9, 8, 0, 0);
		spi(64'h1301ffffff00, 48, -1, 0);
		chk("wide opcode addr", 32'h01ffffff, reqQ[q0].addr);
		$display("test address done");
		spi(64'hb1, 8, 0, 0);
		rchk("secure mode", REG_SECURITY, 32'h4);
		spi(64'h06, 8, 0, 0);
		spi(64'h02000020a5, 40, 1, 0);
		chk("secure flag", 32'h1, {31'h0, reqQ[q0].secure});
		spi(64'h06, 8, 0, 0);
		spi(64'h02000005a5, 40, 0, 1);
		spi(64'h06, 8, 0, 0);
		spi(64'h20000000, 32, 0, 1);
		spi(64'hc1, 8, 0, 0);
		spi(64'h06, 8, 0, 0);
		spi(64'h2f, 8, 0, 0);
		rchk("customer lock", REG_SECURITY, 32'h2);
		apb(1'b1, REG_SECURITY, 32'h1);
		rchk("factory lock", REG_SECURITY, 32'h3);
		spi(64'hb1, 8, 0, 0);
		spi(64'h06, 8, 0, 0);
		spi(64'h02000020a5, 40, 0, 1);
		$display("test secure done");
		close_out;
	end
endmodule
`default_nettype wire
